// File: can_xcvr_pkg.sv
// Package for the CAN transceiver control block: register map, timing constants, carriers.
// Assumes one 250 MHz clock domain and an APB register port.
package can_xcvr_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ            = 250;
  localparam int unsigned TICK_NS            = 1000;
  localparam int unsigned TICK_CYCLES        = (TICK_NS * CLK_MHZ) / 1000;
  localparam int unsigned WAKE_FILTER_US     = 1;
  localparam int unsigned WAKE_RELEASE_US    = 1;
  localparam int unsigned DOM_TIMEOUT_US     = 1000;
  localparam int unsigned STB_TO_NORMAL_US   = 10;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR    = 8'h00;
  localparam logic [7:0] STATUS_ADDR  = 8'h04;
  localparam logic [7:0] WAKE_ADDR    = 8'h08;
  localparam logic [7:0] DOMTO_ADDR   = 8'h0C;
  localparam logic [7:0] RECOV_ADDR   = 8'h10;

  localparam int unsigned CTRL_SWSTB_BIT = 0;
  localparam int unsigned CTRL_SWSEL_BIT = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam logic [15:0] WAKE_RESET     = 16'(WAKE_FILTER_US);
  localparam logic [15:0] DOMTO_RESET    = 16'(DOM_TIMEOUT_US);
  localparam logic [15:0] RECOV_RESET    = 16'(STB_TO_NORMAL_US);

  localparam int unsigned ST_STANDBY_BIT = 0;
  localparam int unsigned ST_WAKE_BIT    = 1;
  localparam int unsigned ST_THERM_BIT   = 2;
  localparam int unsigned ST_DOMTO_BIT   = 3;
  localparam int unsigned ST_UVLOCK_BIT  = 4;
  localparam int unsigned ST_IOUV_BIT    = 5;
  localparam int unsigned ST_TXEN_BIT    = 6;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic main_supply_ok;
    logic main_uv;
    logic io_supply_uv;
    logic over_temp;
  } supply_s;

  typedef struct packed {
    logic drive_dominant;
    logic driver_engaged;
  } bus_drive_s;

endpackage

// File: tick_timer.sv
// Microsecond-tick up-counter that runs while its condition holds.
// Assumes a one-cycle tick enable from the main divider.
`timescale 1ns/1ns
module tick_timer
  import can_xcvr_pkg::*;
#(
  parameter int unsigned W = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         tick_in,
  input  wire logic         run_in,
  input  wire logic [W-1:0] limit_in,
  output logic              expired_out
);

  logic [W-1:0] count_q;

  // Cleared as soon as the qualifying condition drops
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= '0;
    end else if (!run_in) begin
      count_q <= '0;
    end else if (tick_in && count_q < limit_in) begin
      count_q <= count_q + W'(1);
    end
  end

  assign expired_out = run_in && (count_q >= limit_in);

endmodule

// File: can_xcvr_ctrl.sv
// Control logic of a high-speed CAN transceiver: modes, wake-up, protection.
// Assumes analog comparators and supply detectors deliver asynchronous levels.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns

// What this block does
// RULE1 - Standby select low picks normal mode, high picks standby.
// RULE2 - Normal mode: transmit low drives dominant, high leaves recessive.
// RULE3 - Normal mode: receive output low when dominant, high when recessive.
// RULE4 - Standby: transmitter and normal receiver off; low-power receiver watches bus.
// RULE5 - Standby: dominant longer than wake filter drives receive output low.
// RULE6 - Wake not latched; receive returns high after release delay.
// RULE7 - No wake detection without the main supply.
// RULE8 - Over-temperature switches the transmitter off.
// RULE9 - Thermal shutdown affects only the transmitter.
// RULE10 - Thermal off-state ends when hot clears and transmit is high.
// RULE11 - Dominant time-out timer starts on transmit falling edge.
// RULE12 - Transmit low beyond time-out disables transmitter, bus recessive.
// RULE13 - Transmit rising edge resets the timer and re-enables transmission.
// RULE14 - Controller keeps bit rate at or above 15 kbps.
// RULE15 - Main-supply undervoltage blocks all transmission.
// RULE16 - After supply recovery, dominant refused until transmit seen high.
// RULE17 - Undervoltage recovery takes the standby-to-normal delay.
// RULE18 - I/O supply undervoltage releases the driver from the bus.
// RULE19 - Undriven transmit and standby inputs read high.
// RULE20 - Filters and time-out are tick counters cleared when condition ends.
module can_xcvr_ctrl
  import can_xcvr_pkg::*;
#(
  parameter int unsigned TW = 16
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Controller side pins, with pull-up already resolved to 1 when undriven
  input  wire logic        tx_data_in,
  input  wire logic        tx_data_driven_in,
  input  wire logic        standby_sel_in,
  input  wire logic        standby_sel_driven_in,
  output logic             rx_data_out,
  output logic             rx_data_oe_out,
  // Bus comparators
  input  wire logic        bus_dominant_in,
  input  wire logic        lp_bus_dominant_in,
  // Supply and temperature detectors
  input  wire supply_s     supply_in,
  // Analog driver and receiver controls
  output bus_drive_s       drive_out,
  output logic             normal_rx_en_out,
  output logic             lp_rx_en_out,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned NS = 9;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;

  assign raw = {tx_data_in, tx_data_driven_in, standby_sel_in, standby_sel_driven_in,
                bus_dominant_in, lp_bus_dominant_in, supply_in.main_supply_ok,
                supply_in.main_uv | supply_in.io_supply_uv ? supply_in.main_uv : 1'b0,
                supply_in.io_supply_uv};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= 9'h1E4;
      s2_q <= 9'h1E4;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  logic hot_s_q;
  logic hot_m_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hot_m_q <= 1'b0;
      hot_s_q <= 1'b0;
    end else begin
      hot_m_q <= supply_in.over_temp;
      hot_s_q <= hot_m_q;
    end
  end

  logic tx_pin;
  logic stb_pin;
  logic bus_dom;
  logic lp_dom;
  logic vcc_ok;
  logic vcc_uv;
  logic io_uv;
  // Undriven inputs fall back to high (pull-up)
  assign tx_pin  = s2_q[8] | ~s2_q[7];                                  // RULE19
  assign stb_pin = s2_q[6] | ~s2_q[5];                                  // RULE19
  assign bus_dom = s2_q[4];
  assign lp_dom  = s2_q[3];
  assign vcc_ok  = s2_q[2];
  assign vcc_uv  = s2_q[1];
  assign io_uv   = s2_q[0];

  // ---------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------
  logic [15:0] div_q;
  logic        tick;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= '0;
    end else if (div_q == 16'(TICK_CYCLES - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign tick = (div_q == 16'(TICK_CYCLES - 1));

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [1:0]    ctrl_q;
  logic [TW-1:0] wake_lim_q;
  logic [TW-1:0] domto_lim_q;
  logic [TW-1:0] recov_lim_q;
  logic          wr;
  assign wr = psel && penable && pwrite;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q      <= CTRL_RESET;
      wake_lim_q  <= TW'(WAKE_RESET);
      domto_lim_q <= TW'(DOMTO_RESET);
      recov_lim_q <= TW'(RECOV_RESET);
    end else if (wr) begin
      unique case (paddr)
        CTRL_ADDR:  ctrl_q      <= pwdata[1:0];
        WAKE_ADDR:  wake_lim_q  <= pwdata[TW-1:0];
        DOMTO_ADDR: domto_lim_q <= pwdata[TW-1:0];
        RECOV_ADDR: recov_lim_q <= pwdata[TW-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Mode
  // ---------------------------------------------------------------
  logic standby;
  // Software may override the pin for bring-up only
  assign standby = ctrl_q[CTRL_SWSEL_BIT] ? ctrl_q[CTRL_SWSTB_BIT] : stb_pin;  // RULE1

  // ---------------------------------------------------------------
  // Wake-up detection
  // ---------------------------------------------------------------
  logic wake_dom_run;
  logic wake_dom_done;
  logic wake_rel_done;
  logic wake_q;

  // Low-power receiver lives on the main supply
  assign wake_dom_run = standby && vcc_ok && lp_dom;                    // RULE7

  tick_timer #(.W(TW)) u_wake_filt (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .tick_in     (tick),
    .run_in      (wake_dom_run),
    .limit_in    (wake_lim_q),
    .expired_out (wake_dom_done)
  );                                                                    // RULE20

  tick_timer #(.W(TW)) u_wake_rel (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .tick_in     (tick),
    .run_in      (wake_q && !lp_dom),
    .limit_in    (wake_lim_q),
    .expired_out (wake_rel_done)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_q <= 1'b0;
    end else if (!standby || !vcc_ok) begin
      wake_q <= 1'b0;                                                   // RULE7
    end else if (wake_dom_done) begin
      wake_q <= 1'b1;                                                   // RULE5
    end else if (wake_rel_done) begin
      wake_q <= 1'b0;                                                   // RULE6
    end
  end

  // ---------------------------------------------------------------
  // Dominant time-out
  // ---------------------------------------------------------------
  logic tx_prev_q;
  logic domto_done;
  logic domto_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_prev_q <= 1'b1;
    end else begin
      tx_prev_q <= tx_pin;
    end
  end

  // Runs from the falling edge while low; a high level clears it
  tick_timer #(.W(TW)) u_domto (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .tick_in     (tick),
    .run_in      (!tx_pin),                                             // RULE11
    .limit_in    (domto_lim_q),
    .expired_out (domto_done)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      domto_q <= 1'b0;
    end else if (tx_pin && !tx_prev_q) begin
      domto_q <= 1'b0;                                                  // RULE13
    end else if (domto_done) begin
      domto_q <= 1'b1;                                                  // RULE12
    end
  end

  // ---------------------------------------------------------------
  // Thermal shutdown
  // ---------------------------------------------------------------
  logic therm_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      therm_q <= 1'b0;
    end else if (hot_s_q) begin
      therm_q <= 1'b1;                                                  // RULE8
    end else if (tx_pin) begin
      therm_q <= 1'b0;                                                  // RULE10
    end
  end

  // ---------------------------------------------------------------
  // Main supply undervoltage lock and recovery
  // ---------------------------------------------------------------
  logic uv_lock_q;
  logic recov_done;
  // Recovery delay matches standby-to-normal; reset starts locked
  tick_timer #(.W(TW)) u_recov (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .tick_in     (tick),
    .run_in      (uv_lock_q && !vcc_uv),
    .limit_in    (recov_lim_q),
    .expired_out (recov_done)                                           // RULE17
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      uv_lock_q <= 1'b1;
    end else if (vcc_uv) begin
      uv_lock_q <= 1'b1;                                                // RULE15
    end else if (recov_done && tx_pin) begin
      uv_lock_q <= 1'b0;                                                // RULE16
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic tx_enable;
  // Receiver and mode logic ignore the thermal flag
  assign tx_enable = !standby && !therm_q && !domto_q && !uv_lock_q && !io_uv;  // RULE9

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_out        <= '0;
      rx_data_out      <= 1'b1;
      rx_data_oe_out   <= 1'b0;
      normal_rx_en_out <= 1'b0;
      lp_rx_en_out     <= 1'b0;
    end else begin
      drive_out.drive_dominant <= tx_enable && !tx_pin;                 // RULE2
      drive_out.driver_engaged <= !standby && !io_uv;                   // RULE18
      normal_rx_en_out         <= !standby;                             // RULE4
      lp_rx_en_out             <= standby && vcc_ok;                    // RULE4
      rx_data_out              <= standby ? !wake_q : !bus_dom;         // RULE3
      // Pins float without I/O supply
      rx_data_oe_out           <= !io_uv;
    end
  end

  // ---------------------------------------------------------------
  // APB read side
  // ---------------------------------------------------------------
  logic [31:0] rd;
  logic        hit;
  always_comb begin
    rd  = 32'h0;
    hit = 1'b1;
    unique case (paddr)
      CTRL_ADDR:   rd[1:0] = ctrl_q;
      STATUS_ADDR: begin
        rd[ST_STANDBY_BIT] = standby;
        rd[ST_WAKE_BIT]    = wake_q;
        rd[ST_THERM_BIT]   = therm_q;
        rd[ST_DOMTO_BIT]   = domto_q;
        rd[ST_UVLOCK_BIT]  = uv_lock_q;
        rd[ST_IOUV_BIT]    = io_uv;
        rd[ST_TXEN_BIT]    = tx_enable;
      end
      WAKE_ADDR:   rd[TW-1:0] = wake_lim_q;
      DOMTO_ADDR:  rd[TW-1:0] = domto_lim_q;
      RECOV_ADDR:  rd[TW-1:0] = recov_lim_q;
      default:     hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= rd;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

endmodule

// File: can_xcvr_ctrl_sva.sv
// Checker for the transceiver control block, bound by name to its ports.
// Assumes one clock domain; latencies follow the two-flop pin synchronisers.
`timescale 1ns/1ns
module can_xcvr_ctrl_sva
  import can_xcvr_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       tx_data_in,
  input  wire logic       tx_data_driven_in,
  input  wire logic       standby_sel_in,
  input  wire logic       standby_sel_driven_in,
  input  wire logic       rx_data_out,
  input  wire logic       bus_dominant_in,
  input  wire supply_s    supply_in,
  input  wire bus_drive_s drive_out,
  input  wire logic       normal_rx_en_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Undriven select reads as standby
  wire logic stby = standby_sel_in || !standby_sel_driven_in;
  wire logic dd   = drive_out.drive_dominant;
  wire logic txlo = !tx_data_in && tx_data_driven_in;

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  stby_off_a: assert property (stby [*5] |-> !dd && !normal_rx_en_out)
    else $error("driver or receiver active in standby");
  tx_rec_a: assert property (!txlo [*5] |-> !dd)
    else $error("dominant without low transmit");
  io_rel_a: assert property (supply_in.io_supply_uv [*5] |-> !drive_out.driver_engaged)
    else $error("driver engaged under io undervoltage");
  uv_block_a: assert property (supply_in.main_uv [*5] |-> !dd)
    else $error("dominant under main undervoltage");
  hot_off_a: assert property (supply_in.over_temp [*5] |-> !dd)
    else $error("dominant while hot");
  dom_cause_a: assert property ($rose(dd) |-> $past(txlo, 3))
    else $error("dominant rose without low transmit");
  rx_dom_a: assert property ((normal_rx_en_out && bus_dominant_in) [*4] |-> !rx_data_out)
    else $error("receive high on dominant bus");
  rx_rec_a: assert property ((normal_rx_en_out && !bus_dominant_in) [*4] |-> rx_data_out)
    else $error("receive low on recessive bus");
  no_wake_a: assert property ((stby && !supply_in.main_supply_ok) [*4] |-> !$fell(rx_data_out))
    else $error("wake without main supply");
  hot_hold_a: assert property ((supply_in.over_temp && txlo) ##1
    (!supply_in.over_temp && txlo) [*8] |-> !dd)
    else $error("thermal off-state left with transmit low");
endmodule

bind can_xcvr_ctrl can_xcvr_ctrl_sva u_sva (
  .clk_in(clk_in), .rst_in(rst_in), .tx_data_in(tx_data_in),
  .tx_data_driven_in(tx_data_driven_in), .standby_sel_in(standby_sel_in),
  .standby_sel_driven_in(standby_sel_driven_in), .rx_data_out(rx_data_out),
  .bus_dominant_in(bus_dominant_in), .supply_in(supply_in), .drive_out(drive_out),
  .normal_rx_en_out(normal_rx_en_out)
);

// File: can_ctrl_model.sv
// Protocol controller pins and the bus pair as seen by the transceiver.
// Assumes the bench sets wanted pin levels; any node can pull the bus dominant.
`timescale 1ns/1ns
module can_ctrl_model
  import can_xcvr_pkg::*;
(
  input  wire logic       tx_want_in,
  input  wire logic       tx_drive_in,
  input  wire logic       stb_want_in,
  input  wire logic       stb_drive_in,
  input  wire logic       other_dom_in,
  input  wire bus_drive_s drive_in,
  output logic            tx_out,
  output logic            tx_driven_out,
  output logic            stb_out,
  output logic            stb_driven_out,
  output logic            bus_dom_out
);
  // Released pins float to the pull-up level
  assign tx_out         = tx_drive_in ? tx_want_in : 1'b1;
  assign tx_driven_out  = tx_drive_in;
  assign stb_out        = stb_drive_in ? stb_want_in : 1'b1;
  assign stb_driven_out = stb_drive_in;
  assign bus_dom_out    = other_dom_in || (drive_in.drive_dominant && drive_in.driver_engaged);
endmodule

// File: can_transceiver_protection_control_test.sv
// Bench for the transceiver control block: APB tasks and pin scenarios.
// Assumes can_ctrl_model as controller and bus, and the bound checker.
`timescale 1ns/1ns
module can_transceiver_protection_control_test
  import can_xcvr_pkg::*;
  ;
  localparam int T = TICK_CYCLES;
  logic        clk_in, rst_in, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        e, tx_w, tx_d, stb_w, stb_d, oth;
  logic        tx, txdr, stb, stbdr, bdom, rx, rxoe, nrx, lprx;
  supply_s     sup;
  bus_drive_s  drv;
  int          failures, samples_checked;

  always #2 clk_in = ~clk_in;

  can_xcvr_ctrl u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .tx_data_in(tx), .tx_data_driven_in(txdr),
    .standby_sel_in(stb), .standby_sel_driven_in(stbdr), .rx_data_out(rx),
    .rx_data_oe_out(rxoe), .bus_dominant_in(bdom), .lp_bus_dominant_in(bdom),
    .supply_in(sup), .drive_out(drv), .normal_rx_en_out(nrx), .lp_rx_en_out(lprx),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  can_ctrl_model u_ctl (
    .tx_want_in(tx_w), .tx_drive_in(tx_d), .stb_want_in(stb_w), .stb_drive_in(stb_d),
    .other_dom_in(oth), .drive_in(drv), .tx_out(tx), .tx_driven_out(txdr),
    .stb_out(stb), .stb_driven_out(stbdr), .bus_dom_out(bdom)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(r, x);
    chk(e, xe);
  endtask
  task automatic stbit(input int b, input logic x);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(r[b], x);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    #100000;
    failures++;
    $display("unexpected at %0t: watchdog", $time);
    tally_and_finish();
  end

  initial begin
    clk_in = 0; rst_in = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    tx_w = 1; tx_d = 1; stb_w = 0; stb_d = 1; oth = 0;
    sup = '0;
    sup.main_supply_ok = 1'b1;
    cyc(2);
    rst_in <= 1'b0;
    rd(CTRL_ADDR, 32'(CTRL_RESET), 0);
    rd(WAKE_ADDR, 32'(WAKE_RESET), 0);
    rd(DOMTO_ADDR, 32'(DOMTO_RESET), 0);
    rd(RECOV_ADDR, 32'(RECOV_RESET), 0);
    rd(8'h14, 32'h0, 1);
    apb(1'b1, 8'h14, 32'h5);
    chk(e, 1);
    stbit(ST_UVLOCK_BIT, 1);
    // Short limits keep the run small; two ticks avoid the partial first tick
    apb(1'b1, RECOV_ADDR, 32'h2);
    apb(1'b1, DOMTO_ADDR, 32'h4);
    rd(DOMTO_ADDR, 32'h4, 0);
    apb(1'b1, CTRL_ADDR, 32'h3);
    stbit(ST_STANDBY_BIT, 1);
    chk(nrx, 0);
    apb(1'b1, CTRL_ADDR, 32'h0);
    stbit(ST_STANDBY_BIT, 0);
    $display("test registers done");
    cyc(3*T);
    tx_w <= 0; cyc(10);
    chk(drv, 2'b11);
    chk(rx, 0);
    cyc(690);
    chk(drv.drive_dominant, 1);
    cyc(400);
    chk(drv.drive_dominant, 0);
    chk(rx, 1);
    stbit(ST_DOMTO_BIT, 1);
    tx_w <= 1; cyc(10);
    tx_w <= 0; cyc(10);
    chk(drv.drive_dominant, 1);
    $display("test timeout done");
    sup.over_temp <= 1'b1; cyc(10);
    chk(drv.drive_dominant, 0);
    oth <= 1; cyc(10);
    chk(rx, 0);
    oth <= 0; sup.over_temp <= 1'b0; cyc(20);
    chk(drv.drive_dominant, 0);
    stbit(ST_THERM_BIT, 1);
    tx_w <= 1; cyc(10);
    tx_w <= 0; cyc(10);
    chk(drv.drive_dominant, 1);
    tx_w <= 1; stb_w <= 1; cyc(10);
    $display("test thermal done");
    chk({nrx, lprx}, 2'b01);
    tx_w <= 0; cyc(10);
    chk(drv.drive_dominant, 0);
    tx_w <= 1; oth <= 1; cyc(2*T+10);
    chk(rx, 0);
    oth <= 0; cyc(2*T+10);
    chk(rx, 1);
    sup.main_supply_ok <= 1'b0; oth <= 1; cyc(2*T+10);
    chk(rx, 1);
    chk(lprx, 0);
    sup.main_supply_ok <= 1'b1; oth <= 0; stb_w <= 0; sup.main_uv <= 1'b1; cyc(10);
    $display("test standby done");
    tx_w <= 0; cyc(10);
    chk(drv.drive_dominant, 0);
    sup.main_uv <= 1'b0; cyc(600);
    chk(drv.drive_dominant, 0);
    tx_w <= 1; cyc(10);
    tx_w <= 0; cyc(10);
    chk(drv.drive_dominant, 1);
    tx_w <= 1; sup.main_uv <= 1'b1; cyc(10);
    sup.main_uv <= 1'b0; cyc(100);
    tx_w <= 0; cyc(10);
    chk(drv.drive_dominant, 0);
    tx_w <= 1; cyc(2*T+10);
    tx_w <= 0; cyc(10);
    chk(drv.drive_dominant, 1);
    $display("test undervoltage done");
    sup.io_supply_uv <= 1'b1; cyc(10);
    chk({drv.driver_engaged, rxoe}, 2'b00);
    sup.io_supply_uv <= 1'b0; cyc(10);
    chk({drv.driver_engaged, rxoe}, 2'b11);
    tx_d <= 0; stb_d <= 0; cyc(10);
    chk({drv.drive_dominant, nrx}, 2'b00);
    $display("test supplies and pins done");
    tally_and_finish();
  end
endmodule
